// *** inc/access_timing_defines.vh ***
// constants and field layout of the region access-timing block
// How it works
// - different-region follow-on access waits region-switch count, always scaled
// - read/write direction change waits turnaround count, always scaled
// - write recovery idle after writes, scaled when mask bit 6 set
// - read recovery idle after reads, scaled when mask bit 5 set
// - write data hold count, scaled when mask bit 4 set
// - burst beat length count, scaled when mask bit 3 set
// - write wait states always scaled
// - read wait states always scaled
// - command delay count, scaled by mask bit 2; written zero becomes one
// - multiplexed address hold count, scaled by mask bit 1
// - address phase count, scaled by mask bit 0; written zero becomes one
// - reset loads all-ones into every timing register
// - multiplier code 0..4 gives 1,4,8,16,32; reset code 4; rest reserved
`ifndef ACCESS_TIMING_DEFINES_VH
`define ACCESS_TIMING_DEFINES_VH

`define NUM_REGIONS      7
`define REG_RESET        32'hffffffff
`define CFG_RESET        10'h200
`define MULT_RESET       3'h4
`define MASK_RESET       7'h7f

// apb byte offsets: timing words 0x00..0x18, config words 0x20..0x38, status 0x40
`define OFS_TIMING_BASE  12'h000
`define OFS_CONFIG_BASE  12'h020
`define OFS_STATUS       12'h040
`define ADDR_W           12

// timing fields
`define F_SWITCH_LO      0
`define F_SWITCH_HI      3
`define F_TURN_LO        4
`define F_TURN_HI        7
`define F_WRREC_LO       8
`define F_WRREC_HI       10
`define F_RDREC_LO       11
`define F_RDREC_HI       13
`define F_DHOLD_LO       14
`define F_DHOLD_HI       15
`define F_BURST_LO       16
`define F_BURST_HI       18
`define F_WWAIT_LO       19
`define F_WWAIT_HI       21
`define F_RWAIT_LO       22
`define F_RWAIT_HI       24
`define F_CMD_LO         25
`define F_CMD_HI         27
`define F_AHOLD_LO       28
`define F_AHOLD_HI       29
`define F_ADDR_LO        30
`define F_ADDR_HI        31

// config word: multiplier select mask [6:0], multiplier code [9:7]
`define C_MASK_LO        0
`define C_MASK_HI        6
`define C_MULT_LO        7
`define C_MULT_HI        9
`define M_ADDR           0
`define M_AHOLD          1
`define M_CMD            2
`define M_BURST          3
`define M_DHOLD          4
`define M_RDREC          5
`define M_WRREC          6

// multiplier codes
`define MC_X1            3'h0
`define MC_X4            3'h1
`define MC_X8            3'h2
`define MC_X16           3'h3
`define MC_X32           3'h4

`define CNT_W            10

`endif

// *** hdl/timing_store.v ***
// register memory holding one access-timing word per region
`timescale 1ns/1ps
`default_nettype none
`include "access_timing_defines.vh"
module timing_store (
	input  wire        clk,
	input  wire        rst,
	input  wire        wr_en,
	input  wire [2:0]  wr_idx,
	input  wire [31:0] wr_data,
	input  wire [2:0]  rd_idx,
	output reg  [31:0] rd_data
);
	reg [31:0] mem_q [0:`NUM_REGIONS-1];
	integer i;

	always @(posedge clk) begin
		if (rst) begin
			for (i = 0; i < `NUM_REGIONS; i = i + 1) begin
				mem_q[i] <= `REG_RESET;
			end
			rd_data <= `REG_RESET;
		end else begin
			if (wr_en) begin
				mem_q[wr_idx] <= wr_data;
			end
			rd_data <= mem_q[rd_idx];
		end
	end
endmodule
`default_nettype wire

// *** hdl/phase_counter.v ***
// down counter that times one phase of an external access
`timescale 1ns/1ps
`default_nettype none
`include "access_timing_defines.vh"
module phase_counter (
	input  wire             clk,
	input  wire             rst,
	input  wire             load,
	input  wire [`CNT_W-1:0] count,
	output wire             busy,
	output wire             done
);
	reg [`CNT_W-1:0] left_q;

	always @(posedge clk) begin
		if (rst) begin
			left_q <= {`CNT_W{1'b0}};
		end else if (load) begin
			left_q <= count;
		end else if (left_q != {`CNT_W{1'b0}}) begin
			left_q <= left_q - {{(`CNT_W-1){1'b0}}, 1'b1};
		end
	end

	assign busy = (left_q != {`CNT_W{1'b0}});
	assign done = (left_q == {{(`CNT_W-1){1'b0}}, 1'b1});
endmodule
`default_nettype wire

// *** hdl/access_timing.v ***
// seven-region access-timing registers and access phase sequencer
`timescale 1ns/1ps
`default_nettype none
`include "access_timing_defines.vh"
module access_timing (
	input  wire        MCLK,
	input  wire        RST,
	input  wire        PSEL,
	input  wire        PENABLE,
	input  wire        PWRITE,
	input  wire [11:0] PADDR,
	input  wire [31:0] PWDATA,
	output reg  [31:0] PRDATA,
	output reg         PREADY,
	output reg         PSLVERR,
	input  wire        ACC_REQ,
	input  wire [2:0]  ACC_REGION,
	input  wire        ACC_WRITE,
	input  wire        ACC_MUX,
	input  wire        ACC_BURST,
	input  wire [3:0]  ACC_BEATS,
	output reg         ACC_ACK,
	output reg  [2:0]  PHASE,
	output reg         ADDR_HOLD,
	output reg         DATA_HOLD,
	output reg         BEAT,
	output reg         DONE
);
	localparam S_IDLE  = 3'h0;
	localparam S_ADDR  = 3'h1;
	localparam S_AHOLD = 3'h2;
	localparam S_CMD   = 3'h3;
	localparam S_WAIT  = 3'h4;
	localparam S_DATA  = 3'h5;
	localparam S_DHOLD = 3'h6;
	localparam S_REC   = 3'h7;

	// scale factor for a multiplier code; reserved codes act as 32
	function [5:0] mult_of;
		input [2:0] code;
		begin
			case (code)
			`MC_X1:  mult_of = 6'h01;
			`MC_X4:  mult_of = 6'h04;
			`MC_X8:  mult_of = 6'h08;
			`MC_X16: mult_of = 6'h10;
			default: mult_of = 6'h20;
			endcase
		end
	endfunction

	// phase length in bus cycles, optionally scaled
	function [`CNT_W-1:0] scaled;
		input [3:0] raw;
		input       use_mult;
		input [2:0] code;
		reg   [`CNT_W-1:0] m;
		begin
			m = {4'h0, mult_of(code)};
			scaled = use_mult ? (({6'h00, raw} * m) & {`CNT_W{1'b1}})
				: {6'h00, raw};
		end
	endfunction

	function [`CNT_W-1:0] max2;
		input [`CNT_W-1:0] a;
		input [`CNT_W-1:0] b;
		begin
			max2 = (a > b) ? a : b;
		end
	endfunction

	// apb slave
	wire        setup    = PSEL & ~PENABLE;
	wire        in_tim   = (PADDR >= `OFS_TIMING_BASE) && (PADDR < `OFS_CONFIG_BASE)
		&& (PADDR[1:0] == 2'h0) && (PADDR[4:2] < 3'h7);
	wire        in_cfg   = (PADDR >= `OFS_CONFIG_BASE) && (PADDR < `OFS_STATUS)
		&& (PADDR[1:0] == 2'h0) && (PADDR[4:2] < 3'h7);
	wire        in_stat  = (PADDR == `OFS_STATUS);
	wire [2:0]  reg_idx  = PADDR[4:2];
	reg  [1:0]  apb_st_q;
	reg         tim_wr;
	reg  [31:0] tim_wdata;
	wire [31:0] tim_rdata;
	reg  [2:0]  tim_ridx;
	reg  [9:0]  cfg_q [0:`NUM_REGIONS-1];
	integer     k;
	reg  [2:0]  state_q;
	reg  [2:0]  cur_reg_q;
	reg         cur_wr_q;
	reg         cur_mux_q;
	reg         cur_burst_q;
	reg  [3:0]  beats_q;
	reg  [31:0] tp_q;
	reg  [9:0]  cf_q;
	reg  [2:0]  last_reg_q;
	reg         last_wr_q;
	reg         have_last_q;
	reg         fetch_q;
	reg         load;
	reg  [`CNT_W-1:0] load_val;
	wire        cnt_busy;
	wire        cnt_done;
	wire        busy_any = (state_q != S_IDLE);

	// written zero in command delay and address phase counts becomes one
	always @* begin
		tim_wdata = PWDATA;
		if (PWDATA[`F_CMD_HI:`F_CMD_LO] == 3'h0) begin
			tim_wdata[`F_CMD_HI:`F_CMD_LO] = 3'h1;
		end
		if (PWDATA[`F_ADDR_HI:`F_ADDR_LO] == 2'h0) begin
			tim_wdata[`F_ADDR_HI:`F_ADDR_LO] = 2'h1;
		end
	end

	// timing store is read one cycle after setup, so access phase waits one cycle
	always @(posedge MCLK) begin
		if (RST) begin
			apb_st_q <= 2'h0;
			PREADY   <= 1'b0;
			PSLVERR  <= 1'b0;
			PRDATA   <= 32'h00000000;
			tim_wr   <= 1'b0;
			for (k = 0; k < `NUM_REGIONS; k = k + 1) begin
				cfg_q[k] <= `CFG_RESET;
			end
		end else begin
			tim_wr  <= 1'b0;
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
			case (apb_st_q)
			2'h0: begin
				if (setup) begin
					apb_st_q <= 2'h1;
				end
			end
			2'h1: begin
				if (PSEL & PENABLE) begin
					apb_st_q <= 2'h2;
					PREADY   <= 1'b1;
					PSLVERR  <= ~(in_tim | in_cfg | in_stat);
					if (PWRITE) begin
						PRDATA <= 32'h00000000;
						tim_wr <= in_tim;
						if (in_cfg) begin
							cfg_q[reg_idx] <= PWDATA[9:0];
						end
					end else if (in_tim) begin
						PRDATA <= tim_rdata;
					end else if (in_cfg) begin
						PRDATA <= {22'h000000, cfg_q[reg_idx]};
					end else if (in_stat) begin
						PRDATA <= {23'h000000, busy_any, 1'b0, last_wr_q,
							last_reg_q, PHASE};
					end else begin
						PRDATA <= 32'h00000000;
					end
				end else begin
					apb_st_q <= 2'h0;
				end
			end
			default: apb_st_q <= 2'h0;
			endcase
		end
	end

	reg  [2:0]  wr_idx_q;
	reg  [31:0] wr_data_q;
	always @(posedge MCLK) begin
		if (RST) begin
			wr_idx_q  <= 3'h0;
			wr_data_q <= `REG_RESET;
		end else if (apb_st_q == 2'h1) begin
			wr_idx_q  <= reg_idx;
			wr_data_q <= tim_wdata;
		end
	end

	// port arbitration of the store: apb setup steals the read port
	always @* begin
		tim_ridx = (setup & in_tim) ? reg_idx : ACC_REGION;
	end

	timing_store u_store (
		.clk     (MCLK),
		.rst     (RST),
		.wr_en   (tim_wr),
		.wr_idx  (wr_idx_q),
		.wr_data (wr_data_q),
		.rd_idx  (tim_ridx),
		.rd_data (tim_rdata)
	);

	// access sequencer

	wire [2:0] mc = cf_q[`C_MULT_HI:`C_MULT_LO];
	wire [6:0] mm = cf_q[`C_MASK_HI:`C_MASK_LO];
	wire [`CNT_W-1:0] n_addr  = scaled({2'h0, tp_q[`F_ADDR_HI:`F_ADDR_LO]},
		mm[`M_ADDR], mc);
	wire [`CNT_W-1:0] n_ahold = scaled({2'h0, tp_q[`F_AHOLD_HI:`F_AHOLD_LO]},
		mm[`M_AHOLD], mc);
	wire [`CNT_W-1:0] n_cmd   = scaled({1'b0, tp_q[`F_CMD_HI:`F_CMD_LO]},
		mm[`M_CMD], mc);
	wire [`CNT_W-1:0] n_wait  = cur_wr_q
		? scaled({1'b0, tp_q[`F_WWAIT_HI:`F_WWAIT_LO]}, 1'b1, mc)
		: scaled({1'b0, tp_q[`F_RWAIT_HI:`F_RWAIT_LO]}, 1'b1, mc);
	wire [`CNT_W-1:0] n_burst = scaled({1'b0, tp_q[`F_BURST_HI:`F_BURST_LO]},
		mm[`M_BURST], mc);
	wire [`CNT_W-1:0] n_dhold = scaled({2'h0, tp_q[`F_DHOLD_HI:`F_DHOLD_LO]},
		mm[`M_DHOLD], mc);
	wire [`CNT_W-1:0] n_rec   = cur_wr_q
		? scaled({1'b0, tp_q[`F_WRREC_HI:`F_WRREC_LO]}, mm[`M_WRREC], mc)
		: scaled({1'b0, tp_q[`F_RDREC_HI:`F_RDREC_LO]}, mm[`M_RDREC], mc);
	wire [`CNT_W-1:0] n_switch = scaled(tp_q[`F_SWITCH_HI:`F_SWITCH_LO], 1'b1, mc);
	wire [`CNT_W-1:0] n_turn   = scaled(tp_q[`F_TURN_HI:`F_TURN_LO], 1'b1, mc);

	// idle owed before the next access: longest of recovery, switch, turnaround
	reg  [`CNT_W-1:0] rec_q;
	reg  [`CNT_W-1:0] sw_q;
	reg  [`CNT_W-1:0] tn_q;
	wire [`CNT_W-1:0] gap = max2(rec_q, max2(
		(have_last_q && ACC_REGION != last_reg_q) ? sw_q : {`CNT_W{1'b0}},
		(have_last_q && ACC_WRITE != last_wr_q) ? tn_q : {`CNT_W{1'b0}}));
	reg  [`CNT_W-1:0] idle_q;

	phase_counter u_cnt (
		.clk   (MCLK),
		.rst   (RST),
		.load  (load),
		.count (load_val),
		.busy  (cnt_busy),
		.done  (cnt_done)
	);

	// pick the phase after the current one; address hold only when multiplexed, data hold only on writes
	function [2:0] next_after;
		input [2:0] cur;
		input       mux;
		input       wr;
		begin
			case (cur)
			S_ADDR:  next_after = mux ? S_AHOLD : S_CMD;
			S_AHOLD: next_after = S_CMD;
			S_CMD:   next_after = S_WAIT;
			S_WAIT:  next_after = S_DATA;
			S_DATA:  next_after = wr ? S_DHOLD : S_REC;
			default: next_after = S_REC;
			endcase
		end
	endfunction

	function [`CNT_W-1:0] len_of;
		input [2:0] st;
		begin
			case (st)
			S_ADDR:  len_of = n_addr;
			S_AHOLD: len_of = n_ahold;
			S_CMD:   len_of = n_cmd;
			S_WAIT:  len_of = n_wait;
			S_DATA:  len_of = cur_burst_q ? n_burst : {{(`CNT_W-1){1'b0}}, 1'b1};
			S_DHOLD: len_of = n_dhold;
			default: len_of = {`CNT_W{1'b0}};
			endcase
		end
	endfunction

	wire        phase_end = ~cnt_busy | cnt_done;
	wire [2:0]  nxt       = next_after(state_q, cur_mux_q, cur_wr_q);
	wire        last_beat = (beats_q == 4'h0);
	wire        go        = (state_q == S_IDLE) & ACC_REQ & ~fetch_q
		& (idle_q == {`CNT_W{1'b0}}) & (gap == {`CNT_W{1'b0}}) & ~(setup & in_tim);

	always @* begin
		load     = 1'b0;
		load_val = {`CNT_W{1'b0}};
		if (fetch_q) begin
			load     = 1'b1;
			load_val = scaled({2'h0, tim_rdata[`F_ADDR_HI:`F_ADDR_LO]}, mm[`M_ADDR], mc);
		end else if (state_q != S_IDLE && state_q != S_REC && phase_end) begin
			load = 1'b1;
			if (state_q == S_DATA && cur_burst_q && !last_beat) begin
				load_val = len_of(S_DATA);
			end else begin
				load_val = len_of(nxt);
			end
		end
	end

	always @(posedge MCLK) begin
		if (RST) begin
			state_q     <= S_IDLE;
			fetch_q     <= 1'b0;
			cur_reg_q   <= 3'h0;
			cur_wr_q    <= 1'b0;
			cur_mux_q   <= 1'b0;
			cur_burst_q <= 1'b0;
			beats_q     <= 4'h0;
			tp_q        <= `REG_RESET;
			cf_q        <= `CFG_RESET;
			last_reg_q  <= 3'h0;
			last_wr_q   <= 1'b0;
			have_last_q <= 1'b0;
			rec_q       <= {`CNT_W{1'b0}};
			sw_q        <= {`CNT_W{1'b0}};
			tn_q        <= {`CNT_W{1'b0}};
			idle_q      <= {`CNT_W{1'b0}};
			ACC_ACK     <= 1'b0;
			PHASE       <= S_IDLE;
			ADDR_HOLD   <= 1'b0;
			DATA_HOLD   <= 1'b0;
			BEAT        <= 1'b0;
			DONE        <= 1'b0;
		end else begin
			ACC_ACK <= 1'b0;
			BEAT    <= 1'b0;
			DONE    <= 1'b0;
			fetch_q <= 1'b0;
			if (idle_q != {`CNT_W{1'b0}}) begin
				idle_q <= idle_q - {{(`CNT_W-1){1'b0}}, 1'b1};
			end
			if (rec_q != {`CNT_W{1'b0}}) begin
				rec_q <= rec_q - {{(`CNT_W-1){1'b0}}, 1'b1};
			end
			if (sw_q != {`CNT_W{1'b0}}) begin
				sw_q <= sw_q - {{(`CNT_W-1){1'b0}}, 1'b1};
			end
			if (tn_q != {`CNT_W{1'b0}}) begin
				tn_q <= tn_q - {{(`CNT_W-1){1'b0}}, 1'b1};
			end
			if (go) begin
				// store read data arrives next cycle; timing sampled then
				fetch_q     <= 1'b1;
				ACC_ACK     <= 1'b1;
				cur_reg_q   <= ACC_REGION;
				cur_wr_q    <= ACC_WRITE;
				cur_mux_q   <= ACC_MUX;
				cur_burst_q <= ACC_BURST;
				beats_q     <= ACC_BURST ? ACC_BEATS : 4'h0;
				cf_q        <= cfg_q[ACC_REGION];
			end
			if (fetch_q) begin
				tp_q    <= tim_rdata;
				state_q <= S_ADDR;
				PHASE   <= S_ADDR;
			end else if (state_q == S_REC) begin
				// the recovery, switch and turnaround times run from here
				rec_q       <= n_rec;
				sw_q        <= n_switch;
				tn_q        <= n_turn;
				last_reg_q  <= cur_reg_q;
				last_wr_q   <= cur_wr_q;
				have_last_q <= 1'b1;
				state_q     <= S_IDLE;
				PHASE       <= S_IDLE;
				DONE        <= 1'b1;
			end else if (state_q != S_IDLE && phase_end) begin
				if (state_q == S_DATA) begin
					BEAT <= 1'b1;
				end
				if (state_q == S_DATA && cur_burst_q && !last_beat) begin
					beats_q <= beats_q - 4'h1;
				end else begin
					state_q <= nxt;
					PHASE   <= nxt;
				end
			end
			ADDR_HOLD <= (load && !fetch_q && nxt == S_AHOLD && state_q == S_ADDR)
				| (ADDR_HOLD & ~phase_end);
			DATA_HOLD <= (load && !fetch_q && state_q == S_DATA && nxt == S_DHOLD
				&& !(cur_burst_q && !last_beat)) | (DATA_HOLD & ~phase_end);
		end
	end
endmodule
`default_nettype wire

// *** verif/access_timing_assertions.sv ***
// concurrent checks on the ports of the access-timing block
`timescale 1ns/1ps
`default_nettype none
module access_timing_checker (
	input wire logic       MCLK,
	input wire logic       RST,
	input wire logic       ACC_REQ,
	input wire logic       ACC_WRITE,
	input wire logic       ACC_MUX,
	input wire logic       ACC_ACK,
	input wire logic [2:0] PHASE,
	input wire logic       ADDR_HOLD,
	input wire logic       DATA_HOLD,
	input wire logic       DONE
);
	logic wr_q;
	logic mux_q;
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (RST);
	// direction and mode of the access in flight
	always @(posedge MCLK) begin
		if (RST) begin
			wr_q <= 1'b0;
			mux_q <= 1'b0;
		end else if (ACC_ACK) begin
			wr_q <= ACC_WRITE;
			mux_q <= ACC_MUX;
		end
	end
	a_ack_then_addr: assert property (ACC_ACK |=> PHASE == 3'h1)
		else $error("address phase does not follow acknowledge");
	a_busy_no_ack: assert property (PHASE != 3'h0 |-> !ACC_ACK)
		else $error("request acknowledged while busy");
	a_ack_after_req: assert property (ACC_ACK |-> $past(ACC_REQ))
		else $error("acknowledge without request");
	a_hold_needs_mux: assert property (PHASE == 3'h2 |-> mux_q)
		else $error("address hold on a plain access");
	a_dhold_needs_wr: assert property (PHASE == 3'h6 |-> wr_q)
		else $error("data hold on a read");
	a_cmd_before_wait: assert property (PHASE == 3'h4 && $past(PHASE) != 3'h4 |-> $past(PHASE) == 3'h3)
		else $error("wait phase not entered from command delay");
	a_wait_before_data: assert property (PHASE == 3'h5 && $past(PHASE) != 3'h5 |-> $past(PHASE) == 3'h4)
		else $error("data phase not entered from wait");
	a_done_after_rec: assert property (DONE |-> $past(PHASE) == 3'h7 && PHASE == 3'h0)
		else $error("done without recovery");
	a_ahold_marker: assert property (ADDR_HOLD == (PHASE == 3'h2))
		else $error("address hold marker out of step with phase");
	a_dhold_marker: assert property (DATA_HOLD == (PHASE == 3'h6))
		else $error("data hold marker out of step with phase");
	cover property (PHASE == 3'h2);
	cover property (PHASE == 3'h6 ##1 PHASE == 3'h7);
	cover property (DONE && wr_q);
endmodule
bind access_timing access_timing_checker u_chk (.MCLK(MCLK), .RST(RST), .ACC_REQ(ACC_REQ),
	.ACC_WRITE(ACC_WRITE), .ACC_MUX(ACC_MUX), .ACC_ACK(ACC_ACK), .PHASE(PHASE),
	.ADDR_HOLD(ADDR_HOLD), .DATA_HOLD(DATA_HOLD), .DONE(DONE));
`default_nettype wire

// *** verif/ext_mem_model.sv ***
// external memory side: times each bus phase and counts data beats
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic [2:0]  phase,
	input  wire logic        beat,
	output var  logic [10:0] len [0:7],
	output var  logic [3:0]  beats
);
	logic [2:0]  prev_q;
	logic [10:0] run_q;
	always @(posedge mclk) begin
		if (rst) begin
			prev_q <= 3'h0;
			run_q <= 11'h000;
			beats <= 4'h0;
		end else begin
			prev_q <= phase;
			if (phase != prev_q) begin
				run_q <= 11'h001;
				len[prev_q] <= run_q;
			end else
				run_q <= run_q + 11'h001;
			if (phase == 3'h1 && prev_q == 3'h0)
				beats <= 4'h0;
			else if (beat)
				beats <= beats + 4'h1;
		end
	end
endmodule
`default_nettype wire

// *** verif/tb.sv ***
// self-checking bench for the region access-timing block
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        MCLK, RST, PSEL, PENABLE, PWRITE, err;
	logic        ACC_REQ, ACC_WRITE, ACC_MUX, ACC_BURST;
	logic [11:0] PADDR;
	logic [31:0] PWDATA, rd;
	logic [2:0]  ACC_REGION;
	logic [3:0]  ACC_BEATS, beats;
	logic [10:0] len [0:7];
	wire  [31:0] PRDATA;
	wire         PREADY, PSLVERR, ACC_ACK, ADDR_HOLD, DATA_HOLD, BEAT, DONE;
	wire  [2:0]  PHASE;
	integer      mismatches, samples_checked, m, c, r;
	access_timing u_dut (.MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .ACC_REQ(ACC_REQ), .ACC_REGION(ACC_REGION), .ACC_WRITE(ACC_WRITE),
		.ACC_MUX(ACC_MUX), .ACC_BURST(ACC_BURST), .ACC_BEATS(ACC_BEATS), .ACC_ACK(ACC_ACK),
		.PHASE(PHASE), .ADDR_HOLD(ADDR_HOLD), .DATA_HOLD(DATA_HOLD), .BEAT(BEAT), .DONE(DONE));
	ext_mem_model u_mem (.mclk(MCLK), .rst(RST), .phase(PHASE), .beat(BEAT), .len(len),
		.beats(beats));
	task close_out;
		begin
			$display("checks %0d mismatches %0d", samples_checked, mismatches);
			if (mismatches == 0 && samples_checked > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask
	task check(input [31:0] seen, input [31:0] exp);
		begin
			samples_checked = samples_checked + 1;
			if (seen !== exp) begin
				mismatches = mismatches + 1;
				$display("Error at %0t: saw %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task tick(inout integer n);
		begin
			@(posedge MCLK);
			n = n + 1;
			if (n > 3000) begin
				mismatches = mismatches + 1;
				$display("Error at %0t: wait timed out", $time);
				close_out;
			end
		end
	endtask
	task apb(input w, input [11:0] a, input [31:0] d);
		integer n;
		begin
			n = 0;
			PSEL <= 1'b1;
			PWRITE <= w;
			PADDR <= a;
			PWDATA <= d;
			@(posedge MCLK);
			PENABLE <= 1'b1;
			tick(n);
			while (PREADY !== 1'b1)
				tick(n);
			rd = PRDATA;
			err = PSLVERR;
			PSEL <= 1'b0;
			PENABLE <= 1'b0;
			@(posedge MCLK);
		end
	endtask
	task access(input [2:0] rg, input w, input x, input b);
		integer n;
		begin
			n = 0;
			ACC_REQ <= 1'b1;
			ACC_REGION <= rg;
			ACC_WRITE <= w;
			ACC_MUX <= x;
			ACC_BURST <= b;
			ACC_BEATS <= {3'h0, b};
			tick(n);
			while (ACC_ACK !== 1'b1)
				tick(n);
			ACC_REQ <= 1'b0;
			tick(n);
			while (DONE !== 1'b1)
				tick(n);
			@(posedge MCLK);
		end
	endtask
	initial begin
		MCLK = 1'b0;
		forever #12.5 MCLK = ~MCLK;
	end
	initial begin
		{RST, PSEL, PENABLE, PWRITE, ACC_REQ, ACC_WRITE, ACC_MUX, ACC_BURST} = 8'hff;
		{PSEL, PENABLE, PWRITE, ACC_REQ, ACC_WRITE, ACC_MUX, ACC_BURST} = 7'h00;
		{PADDR, PWDATA, ACC_REGION, ACC_BEATS} = 51'h0;
		mismatches = 0;
		samples_checked = 0;
		repeat (10) @(posedge MCLK);
		RST <= 1'b0;
		for (c = 0; c < 7; c = c + 1) begin
			apb(1'b0, 12'(4 * c), 32'h0);
			check(rd, 32'hffffffff);
			apb(1'b0, 12'(32 + 4 * c), 32'h0);
			check(rd, 32'h00000200);
		end
		apb(1'b0, 12'h044, 32'h0);
		check({rd[31:1], err}, 32'h00000001);
		apb(1'b1, 12'h000, 32'h0);
		apb(1'b0, 12'h000, 32'h0);
		check(rd, 32'h42000000);
		for (c = 0; c < 5; c = c + 1) begin
			m = (c == 0) ? 1 : (2 << c);
			// addr 2, ahold 1, cmd 3, rwait 1, wwait 2, burst 2, dhold 1, rec 1/1, turn 3, switch 5
			for (r = 1; r < 3; r = r + 1) begin
				apb(1'b1, 12'(4 * r), 32'h96524935);
				apb(1'b1, 12'(32 + 4 * r), (c << 7) | 32'h7f);
			end
			apb(1'b0, 12'h024, 32'h0);
			check(rd, (c << 7) | 32'h7f);
			access(3'h1, 1'b1, 1'b1, 1'b1);
			check(len[1], 2 * m);
			check(len[2], m);
			check(len[3], 3 * m);
			check(len[4], 2 * m);
			check(len[5], 4 * m);
			check(len[6], m);
			check(beats, 2);
			access(3'h1, 1'b0, 1'b0, 1'b0);
			check(len[0] >= 3 * m && len[0] <= 3 * m + 5, 1);
			check(len[4], m);
			check(len[5], 1);
			access(3'h2, 1'b0, 1'b0, 1'b0);
			check(len[0] >= 5 * m && len[0] <= 5 * m + 5, 1);
			access(3'h2, 1'b0, 1'b0, 1'b0);
			check(len[0] >= m && len[0] <= m + 5, 1);
			access(3'h2, 1'b1, 1'b0, 1'b0);
			access(3'h2, 1'b1, 1'b0, 1'b0);
			check(len[0] >= m && len[0] <= m + 5, 1);
		end
		close_out;
	end
endmodule
`default_nettype wire
